/* File: hw/css_defines.vh */
// Constants for the card status sense block
`ifndef CSS_DEFINES_VH
`define CSS_DEFINES_VH

`define CSS_NUM_SOCKETS 4
`define CSS_CLK_MHZ 200

// Register byte offsets
`define CSS_OFS_IFACE_STATUS 12'h000
`define CSS_OFS_CONTROL 12'h004
`define CSS_OFS_POWER_CONFIG 12'h008
`define CSS_OFS_IRQ_STATUS 12'h00c
`define CSS_OFS_IRQ_MASK 12'h010

// Interface status fields, one byte per socket
`define CSS_IS_DET_ONE 0
`define CSS_IS_DET_TWO 1
`define CSS_IS_GOOD 2
`define CSS_IS_WARN 3
`define CSS_IS_DEAD 4
`define CSS_IS_CHG 5

// Control fields
`define CSS_CTL_PWR_LSB 0
`define CSS_CTL_IO_LSB 4
`define CSS_CTL_SAMPLE 8
`define CSS_CTL_RESET 9'h100

// Power configuration fields, one byte per socket
`define CSS_PC_SENSE_ONE 0
`define CSS_PC_SENSE_TWO 1
`define CSS_PC_VALID 2
`define CSS_PC_ON 3

// Interrupt status layout
`define CSS_IRQ_CHG_LSB 0
`define CSS_IRQ_BATT_LSB 4
`define CSS_IRQ_VS_LSB 8
`define CSS_IRQ_WIDTH 12
`define CSS_IRQ_MASK_RESET 12'h000

// Voltage sense settle time before sampling
`define CSS_VS_SETTLE_NS 100
`define CSS_VS_SETTLE_CYC ((`CSS_VS_SETTLE_NS * `CSS_CLK_MHZ + 999) / 1000)

`endif

/* File: hw/css_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module css_sync #(
  parameter W = 4
) (
  input wire CLK_SYS,
  input wire RESETN,
  input wire CE,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  // Pins idle high through pull-ups, so reset to ones
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s1 <= {W{1'b1}};
      s2 <= {W{1'b1}};
      s3 <= {W{1'b1}};
      q <= {W{1'b1}};
    end else if (CE) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i]; // RL12
        end
      end
    end
  end
endmodule // css_sync
`default_nettype wire

/* File: hw/css_vsense.v */
// Per-socket supply sequencer with voltage sense sampling
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.vh"
module css_vsense (
  input wire CLK_SYS,
  input wire RESETN,
  input wire CE,
  input wire power_req,
  input wire sample_mode,
  input wire sense_one,
  input wire sense_two,
  output reg power_on,
  output reg [1:0] vs_sampled,
  output reg vs_valid,
  output reg done
);
  localparam ST_OFF = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_ON = 3'b100;
  localparam SETTLE_CYC = `CSS_VS_SETTLE_CYC;
  localparam [7:0] SETTLE = SETTLE_CYC[7:0];

  reg [2:0] state;
  reg [7:0] count;

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_OFF;
      count <= 8'h00;
      power_on <= 1'b0;
      vs_sampled <= 2'b00;
      vs_valid <= 1'b0;
      done <= 1'b0;
    end else if (CE) begin
      done <= 1'b0;
      case (state)
        ST_OFF: begin
          power_on <= 1'b0;
          count <= 8'h00;
          if (power_req && sample_mode) begin
            vs_valid <= 1'b0;
            state <= ST_SAMPLE;
          end else if (power_req) begin
            power_on <= 1'b1;
            state <= ST_ON;
          end
        end
        // Supply stays off until the sense pins have settled
        ST_SAMPLE: begin
          if (!power_req) begin
            state <= ST_OFF;
          end else if (count >= SETTLE - 8'h01) begin
            vs_sampled <= {sense_two, sense_one}; // RL10
            vs_valid <= 1'b1; // RL11
            done <= 1'b1;
            power_on <= 1'b1;
            state <= ST_ON;
          end else begin
            count <= count + 8'h01;
          end
        end
        ST_ON: begin
          if (!power_req) begin
            power_on <= 1'b0;
            state <= ST_OFF;
          end
        end
        default: begin
          state <= ST_OFF;
          power_on <= 1'b0;
        end
      endcase
    end
  end
endmodule // css_vsense
`default_nettype wire

/* File: hw/css_top.v */
// Card status sense block: pin sensing, status registers, APB slave
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.vh"
// Contract
// RL1: Both detect inputs high means battery good
// RL2: Detect two low, one high means warning
// RL3: Detect one low means battery dead
// RL4: Card holds status-change high unless both set
// RL5: Card drives status-change low when both set
// RL6: Card changed bit ORs its four flags
// RL7: Detect one level captured in interface status
// RL8: Detect two audio routed to host speaker
// RL9: Detect two level captured in interface status
// RL10: Sample voltage sense before supply on; with control bit 8 clear the supply turns on unsampled
// RL11: Store sampled sense levels in power config
// RL12: Synchronise card inputs before use
module css_top (
  input wire CLK_SYS,
  input wire RESETN,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire [3:0] BATTERY_DETECT_ONE,
  input wire [3:0] BATTERY_DETECT_TWO,
  input wire [3:0] VOLTAGE_SENSE_ONE,
  input wire [3:0] VOLTAGE_SENSE_TWO,
  output reg HOST_SPEAKER_OUT_N,
  output reg [3:0] SOCKET_POWER_ON,
  output reg IRQ
);
  // Battery condition as one-hot {dead, warn, good}
  function [2:0] css_batt_state;
    input b1;
    input b2;
    begin
      if (!b1) begin
        css_batt_state = 3'b100; // RL3
      end else if (!b2) begin
        css_batt_state = 3'b010; // RL2
      end else begin
        css_batt_state = 3'b001; // RL1
      end
    end
  endfunction

  function css_addr_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      css_addr_hit = (addr == ofs);
    end
  endfunction

  // Power configuration byte of one socket
  function [7:0] css_pc_byte;
    input sense_one;
    input sense_two;
    input valid;
    input on;
    begin
      css_pc_byte = 8'h00;
      css_pc_byte[`CSS_PC_SENSE_ONE] = sense_one;
      css_pc_byte[`CSS_PC_SENSE_TWO] = sense_two;
      css_pc_byte[`CSS_PC_VALID] = valid;
      css_pc_byte[`CSS_PC_ON] = on;
    end
  endfunction

  // Interface status byte of one socket
  function [7:0] css_is_byte;
    input b1;
    input b2;
    input io;
    reg [2:0] batt;
    begin
      batt = css_batt_state(b1, b2);
      css_is_byte = 8'h00;
      css_is_byte[`CSS_IS_DET_ONE] = b1; // RL7
      css_is_byte[`CSS_IS_DET_TWO] = b2; // RL9
      if (io) begin
        css_is_byte[`CSS_IS_CHG] = !b1;
      end else begin
        css_is_byte[`CSS_IS_GOOD] = batt[0];
        css_is_byte[`CSS_IS_WARN] = batt[1];
        css_is_byte[`CSS_IS_DEAD] = batt[2];
      end
    end
  endfunction

  wire [3:0] battery_detect_one;
  wire [3:0] battery_detect_two;
  wire [3:0] voltage_sense_one;
  wire [3:0] voltage_sense_two;
  wire [3:0] card_status_changed_n;
  wire [3:0] card_audio_in_n;
  wire [3:0] pwr_on;
  wire [3:0] vs_valid;
  wire [3:0] vs_done;
  wire [7:0] vs_sampled;

  reg [8:0] control;
  reg [31:0] iface_status;
  reg [11:0] irq_status;
  reg [11:0] irq_mask;
  reg [3:0] prev_chg_n;
  reg [11:0] prev_batt;

  reg [31:0] next_iface_status;
  reg [31:0] power_config;
  reg [11:0] events;
  reg [11:0] next_irq_status;
  reg [11:0] batt_now;
  reg [3:0] spk;
  reg [31:0] rd_mux;
  reg rd_hit;
  integer s;

  wire [3:0] power_req = control[3:0];
  wire [3:0] io_mode = control[7:4];
  wire sample_mode = control[`CSS_CTL_SAMPLE];

  wire setup = PSEL && !PENABLE;
  wire access_done = PSEL && PENABLE && PREADY;
  wire wr_done = access_done && PWRITE && !PSLVERR;
  wire rd_done = access_done && !PWRITE && !PSLVERR;

  // Register decode shared by read-clear, error and write paths
  wire hit_ctrl = css_addr_hit(PADDR, `CSS_OFS_CONTROL);
  wire hit_irqs = css_addr_hit(PADDR, `CSS_OFS_IRQ_STATUS);
  wire hit_mask = css_addr_hit(PADDR, `CSS_OFS_IRQ_MASK);
  // Only control and mask take writes; the rest are views
  wire wr_ok = hit_ctrl || hit_mask;
  wire next_irq = |(next_irq_status & irq_mask);

  // Pins share a status-change and an audio meaning
  assign card_status_changed_n = battery_detect_one;
  assign card_audio_in_n = battery_detect_two;

  // Detect pins and sense pins settle independently
  css_sync #(
    .W(8)
  ) u_sync_batt (
    .CLK_SYS(CLK_SYS),
    .RESETN(RESETN),
    .CE(CE),
    .d({BATTERY_DETECT_TWO, BATTERY_DETECT_ONE}),
    .q({battery_detect_two, battery_detect_one}) // RL12
  );

  css_sync #(
    .W(8)
  ) u_sync_sense (
    .CLK_SYS(CLK_SYS),
    .RESETN(RESETN),
    .CE(CE),
    .d({VOLTAGE_SENSE_TWO, VOLTAGE_SENSE_ONE}),
    .q({voltage_sense_two, voltage_sense_one}) // RL12
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_sock
      css_vsense u_vsense (
        .CLK_SYS(CLK_SYS),
        .RESETN(RESETN),
        .CE(CE),
        .power_req(power_req[g]),
        .sample_mode(sample_mode),
        .sense_one(voltage_sense_one[g]),
        .sense_two(voltage_sense_two[g]),
        .power_on(pwr_on[g]),
        .vs_sampled(vs_sampled[2*g+1:2*g]),
        .vs_valid(vs_valid[g]),
        .done(vs_done[g])
      );
    end
  endgenerate

  // Status view and event detection per socket
  always @* begin
    next_iface_status = 32'h00000000;
    power_config = 32'h00000000;
    events = 12'h000;
    batt_now = 12'h000;
    spk = 4'h0;
    for (s = 0; s < 4; s = s + 1) begin
      next_iface_status[8*s+:8] = css_is_byte(battery_detect_one[s],
        battery_detect_two[s], io_mode[s]); // RL7 RL9
      batt_now[3*s+:3] = css_batt_state(battery_detect_one[s],
                                        battery_detect_two[s]);
      // Battery decode is meaningless for an I/O card
      if (!io_mode[s]) begin
        if (batt_now[3*s+:3] != prev_batt[3*s+:3]) begin
          events[`CSS_IRQ_BATT_LSB+s] = 1'b1;
        end
      end else begin
        // Card pulls low only while its changed bit is set
        if (prev_chg_n[s] && !card_status_changed_n[s]) begin
          events[`CSS_IRQ_CHG_LSB+s] = 1'b1; // RL5
        end
        spk[s] = !card_audio_in_n[s]; // RL8
      end
      events[`CSS_IRQ_VS_LSB+s] = vs_done[s];
      power_config[8*s+:8] = css_pc_byte(vs_sampled[2*s],
        vs_sampled[2*s+1], vs_valid[s], pwr_on[s]); // RL11
    end
  end

  // Read of the status register clears, but a new event wins
  always @* begin
    next_irq_status = irq_status;
    if (rd_done && hit_irqs) begin
      next_irq_status = 12'h000;
    end
    next_irq_status = next_irq_status | events;
  end

  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (PADDR)
      `CSS_OFS_IFACE_STATUS: rd_mux = iface_status;
      `CSS_OFS_CONTROL: rd_mux = {23'h000000, control};
      `CSS_OFS_POWER_CONFIG: rd_mux = power_config;
      `CSS_OFS_IRQ_STATUS: rd_mux = {20'h00000, irq_status};
      `CSS_OFS_IRQ_MASK: rd_mux = {20'h00000, irq_mask};
      default: rd_hit = 1'b0;
    endcase
  end

  // One-cycle access phase: PREADY rises with the access cycle
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
    end else if (CE) begin
      PREADY <= setup;
    end
  end

  // Read data stands only in the access cycle
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (CE) begin
      if (setup) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
      end else if (access_done) begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (setup) begin
        PSLVERR <= !rd_hit || (PWRITE && !wr_ok);
      end else if (access_done) begin
        PSLVERR <= 1'b0;
      end
    end
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      control <= `CSS_CTL_RESET;
    end else if (CE && wr_done && hit_ctrl) begin
      control <= PWDATA[8:0];
    end
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_mask <= `CSS_IRQ_MASK_RESET;
    end else if (CE && wr_done && hit_mask) begin
      irq_mask <= PWDATA[11:0];
    end
  end

  // Registered status view and the history edges are found from
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      iface_status <= 32'h00000000;
      prev_chg_n <= 4'hf;
      prev_batt <= 12'h249;
    end else if (CE) begin
      iface_status <= next_iface_status; // RL7
      prev_chg_n <= card_status_changed_n;
      prev_batt <= batt_now;
    end
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_status <= 12'h000;
    end else if (CE) begin
      irq_status <= next_irq_status;
    end
  end

  // Sockets mix by exclusive-or, as a single-bit speaker line
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      HOST_SPEAKER_OUT_N <= 1'b1;
    end else if (CE) begin
      HOST_SPEAKER_OUT_N <= !(^spk); // RL8
    end
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      SOCKET_POWER_ON <= 4'h0;
    end else if (CE) begin
      SOCKET_POWER_ON <= pwr_on; // RL10
    end
  end

  // Level follows the status it holds next, so a clear drops it at once
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= next_irq;
    end
  end
endmodule // css_top
`default_nettype wire

/* File: dv/css_top_asserts.sv */
// Port-level checks for the card status sense top
`timescale 1ns/1ps
`default_nettype none
module css_top_asserts (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] BATTERY_DETECT_TWO,
  input wire logic HOST_SPEAKER_OUT_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  a_ready_after_setup: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY && CE |=> !PREADY)
    else $error("ready held too long");
  a_unmapped_err: assert property
    (PSEL && !PENABLE && CE && PADDR > 12'h010 |=> PREADY && PSLVERR)
    else $error("unmapped access not refused");
  a_ro_write_err: assert property
    (PSEL && !PENABLE && CE && PWRITE && PADDR == 12'h000 |=> PSLVERR)
    else $error("status write not refused");
  a_ctrl_no_err: assert property
    (PSEL && !PENABLE && CE && PADDR == 12'h004 |=> !PSLVERR)
    else $error("control access refused");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  a_quiet_speaker: assert property
    ((BATTERY_DETECT_TWO == 4'hf)[*8] |-> HOST_SPEAKER_OUT_N)
    else $error("speaker active without audio");
endmodule // css_top_asserts
bind css_top css_top_asserts u_chk (.CLK_SYS, .RESETN, .CE, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .BATTERY_DETECT_TWO,
  .HOST_SPEAKER_OUT_N);
`default_nettype wire

/* File: dv/css_card_model.sv */
// Behavioural card in socket zero
`timescale 1ns/1ps
`default_nettype none
module css_card_model (
  input wire logic io_mode,
  input wire logic [1:0] batt,
  input wire logic sig_en,
  input wire logic [3:0] flags,
  input wire logic audio_n,
  input wire logic [1:0] vs_code,
  output logic bd1,
  output logic bd2,
  output logic sense_one,
  output logic sense_two
);
  logic changed;
  assign changed = |flags;
  assign bd1 = io_mode ? ~(sig_en & changed) : batt[0];
  assign bd2 = io_mode ? audio_n : batt[1];
  assign sense_one = vs_code[0];
  assign sense_two = vs_code[1];
endmodule // css_card_model
`default_nettype wire

/* File: dv/test_card_status_sense.sv */
// Self-checking bench for the card status sense top
`timescale 1ns/1ps
`default_nettype none
module test_card_status_sense;
  logic clk = 0, rstn = 0, ce = 1, psel = 0, pen = 0, pwr = 0, e;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, r;
  logic io = 0, sig_en = 0, aud_n = 1;
  logic [1:0] batt = 3, vs = 0;
  logic [3:0] fl = 0;
  logic [2:0] ob1 = 7, ob2 = 7;
  wire [31:0] prd;
  wire prdy, perr, spk_n, irq, bd1, bd2, v1, v2;
  wire [3:0] pwr_on;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  css_card_model u_card (.io_mode(io), .batt(batt), .sig_en(sig_en),
    .flags(fl), .audio_n(aud_n), .vs_code(vs), .bd1(bd1), .bd2(bd2),
    .sense_one(v1), .sense_two(v2));
  css_top u_dut (.CLK_SYS(clk), .RESETN(rstn), .CE(ce), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .BATTERY_DETECT_ONE({ob1, bd1}),
    .BATTERY_DETECT_TWO({ob2, bd2}), .VOLTAGE_SENSE_ONE({ob1, v1}),
    .VOLTAGE_SENSE_TWO({ob1, v2}), .HOST_SPEAKER_OUT_N(spk_n),
    .SOCKET_POWER_ON(pwr_on), .IRQ(irq));
  task end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, x, g);
    end
  endtask
  // Read value is taken from before the edge that samples ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, 12'h004, 0);
    chk("ctrl", 32'h100, r);
    apb(0, 12'h010, 0);
    chk("mask", 0, r);
    chk("spk", 1, spk_n);
    chk("pwr", 0, pwr_on);
    apb(0, 12'h020, 0);
    chk("unmapped", 1, e);
    chk("unmapped rd", 0, r);
    apb(1, 12'h000, 1);
    chk("ro write", 1, e);
    for (int i = 0; i < 4; i++) begin
      batt <= i[1:0];
      wt(10);
      apb(0, 12'h000, 0);
      chk("batt", {24'h070707, 3'b0, ~i[0], i[0] & ~i[1], i[0] & i[1],
        i[1], i[0]}, r);
    end
    apb(1, 12'h010, 1);
    apb(1, 12'h004, 32'h110);
    io <= 1;
    sig_en <= 1;
    wt(10);
    apb(0, 12'h00c, 0);
    for (int i = 0; i < 4; i++) begin
      fl <= 4'h1 << i;
      wt(10);
      chk("irq", 1, irq);
      apb(0, 12'h000, 0);
      chk("io stat", 32'h07070722, r);
      apb(0, 12'h00c, 0);
      chk("irq stat", 1, r[3:0]);
      wt(2);
      chk("irq clr", 0, irq);
      fl <= 0;
      wt(10);
    end
    // Enable off: card must keep the line high
    sig_en <= 0;
    fl <= 4'h8;
    wt(10);
    apb(0, 12'h000, 0);
    chk("no chg", 32'h07070703, r);
    apb(1, 12'h010, 0);
    sig_en <= 1;
    wt(10);
    chk("masked", 0, irq);
    apb(0, 12'h00c, 0);
    chk("masked stat", 1, r[3:0]);
    fl <= 0;
    aud_n <= 0;
    wt(10);
    chk("spk on", 0, spk_n);
    ob2 <= 0;
    aud_n <= 1;
    wt(10);
    chk("spk mem", 1, spk_n);
    ob2 <= 7;
    // Clock enable low must freeze the speaker path
    ce <= 0;
    aud_n <= 0;
    wt(10);
    chk("frozen spk", 1, spk_n);
    ce <= 1;
    wt(10);
    chk("thawed spk", 0, spk_n);
    aud_n <= 1;
    wt(10);
    vs <= 2'b10;
    apb(1, 12'h004, 32'h111);
    wt(10);
    chk("early pwr", 0, pwr_on[0]);
    wt(20);
    chk("pwr on", 1, pwr_on[0]);
    apb(0, 12'h008, 0);
    chk("vs cfg", 8'h0e, r[7:0]);
    apb(0, 12'h00c, 0);
    chk("vs event", 4'h1, r[11:8]);
    apb(1, 12'h004, 32'h012);
    wt(3);
    chk("pwr sock1", 4'h2, pwr_on);
    end_sim;
  end
endmodule // test_card_status_sense
`default_nettype wire
